// ### ui_relay_defs.vh
`ifndef UI_RELAY_DEFS_VH
`define UI_RELAY_DEFS_VH

// ****************************************************************
// Address field layout (52 bits: 6-byte callsign + 4-bit identifier)
// ****************************************************************
`define CALL_W 48
`define SSID_W 4
`define ADDR_W 52
`define MAX_RPT 8
`define SPECIAL_N 4
`define HIST_DEPTH 64
`define CRC_W 16
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h8408

// ****************************************************************
// Timing: one second of hold ticks at 100 MHz
// ****************************************************************
`define CLK_HZ 100000000
`define SEC_NS 1000000000
`define SEC_CYCLES (`SEC_NS / 10)
`define FLOOD_HOLD_DEF 8'h1E
`define TRACE_HOLD_DEF 8'h1E

// ****************************************************************
// Relay kinds
// ****************************************************************
`define KIND_NONE 3'h0
`define KIND_SPECIAL 3'h1
`define KIND_FLOOD 3'h2
`define KIND_TRACE 3'h3
`define KIND_GATE 3'h4

`endif

// ### dup_history.v
`timescale 1ns/1ps
`default_nettype none
`include "ui_relay_defs.vh"

// ****************************************************************
// Duplicate checksum history with per-entry expiry
// ****************************************************************
module dup_history #(
    parameter DEPTH = `HIST_DEPTH,
    parameter AW = 6,
    parameter CW = `CRC_W
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire tick_i,
    input wire lookup_i,
    input wire [CW-1:0] crc_i,
    input wire insert_i,
    input wire [7:0] hold_i,
    output reg hit_o
);

    reg [CW-1:0] sum_q [0:DEPTH-1]; // Stored checksums
    reg [7:0] life_q [0:DEPTH-1]; // Remaining seconds, 0 means empty
    reg [AW-1:0] wr_q; // Oldest slot pointer
    wire [DEPTH-1:0] match_w; // Per-entry comparator

    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
            assign match_w[g] = (life_q[g] != 8'h00) && (sum_q[g] == crc_i);
            // Count down, free on expiry, load on insert
            always @(posedge clk_i) begin
                if (!rst_n_i) begin
                    life_q[g] <= 8'h00;
                    sum_q[g] <= {CW{1'b0}};
                end else if (insert_i && (wr_q == g)) begin
                    life_q[g] <= hold_i;
                    sum_q[g] <= crc_i;
                end else if (tick_i && (life_q[g] != 8'h00)) begin
                    life_q[g] <= life_q[g] - 8'h01;
                end
            end
        end
    endgenerate

    // Ring pointer: a full history overwrites its oldest entry
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_q <= {AW{1'b0}};
            hit_o <= 1'b0;
        end else begin
            if (insert_i && (hold_i != 8'h00)) begin
                wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            hit_o <= lookup_i && (|match_w);
        end
    end

endmodule
`default_nettype wire

// ### ui_frame_digipeater.v
`timescale 1ns/1ps
`default_nettype none
`include "ui_relay_defs.vh"

module ui_frame_digipeater #(
    parameter SEC_CYCLES = `SEC_CYCLES
) (
    input wire clk_i,
    input wire rst_n_i,
    // Received frame header summary from the frame receiver
    input wire hdr_valid_i,
    input wire rx_port_i,
    input wire is_ui_i,
    input wire [`CALL_W-1:0] src_call_i,
    input wire [`CALL_W-1:0] next_call_i,
    input wire [`SSID_W-1:0] next_ssid_i,
    input wire [3:0] next_index_i,
    input wire [3:0] rpt_count_i,
    input wire own_in_path_i,
    input wire [`CRC_W-1:0] frame_crc_i,
    // Configuration
    input wire [`CALL_W-1:0] own_callsign_i,
    input wire [`CALL_W-1:0] gateway_alias_i,
    input wire [1:0] port_gateway_enable_i,
    input wire [1:0] list_op_i,
    input wire list_port_i,
    input wire [`CALL_W-1:0] list_call_i,
    input wire flood_en_i,
    input wire [`CALL_W-1:0] flood_alias_relay_i,
    input wire [2:0] flood_alias_len_i,
    input wire no_callsign_insert_i,
    input wire trace_en_i,
    input wire [`CALL_W-1:0] trace_alias_relay_i,
    input wire [2:0] trace_alias_len_i,
    input wire [7:0] relay_duplicate_hold_i,
    input wire [7:0] flood_hold_i,
    input wire [7:0] trace_hold_i,
    input wire special_wait_i,
    // Unconnected-mode path
    input wire path_none_i,
    input wire path_send_i,
    input wire path_beacon_i,
    // Relay decision and unconnected-mode send gate to the transmit queues
    output reg dec_valid_o,
    output reg dec_relay_o,
    output reg [2:0] dec_kind_o,
    output reg dec_tx_port_o,
    output reg [`CALL_W-1:0] dec_call_o,
    output reg [`SSID_W-1:0] dec_ssid_o,
    output reg dec_hbit_o,
    output reg [3:0] dec_index_o,
    output reg dec_insert_o,
    output reg dec_append_o,
    output reg dec_wait_o,
    output reg ucon_send_o,
    output reg ucon_ui_o,
    output reg ucon_retry_o
);

    // ************************************************************
    // Special relay callsign lists
    // ************************************************************
    reg [`CALL_W-1:0] list_call_q [0:7]; // Two ports times four entries
    reg [7:0] list_used_q; // Occupied flags
    wire [2:0] list_base_w; // First slot of the addressed port
    wire [7:0] list_hit_w; // Entry matches add or remove call
    reg [2:0] free_slot_w; // First free entry of the port
    reg free_any_w; // Port has space
    integer i;

    assign list_base_w = {list_port_i, 2'b00};

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_cmp
            assign list_hit_w[g] = list_used_q[g] && (list_call_q[g] == list_call_i);
        end
    endgenerate

    // Locate a free entry on the addressed port
    always @* begin
        free_slot_w = 3'h0;
        free_any_w = 1'b0;
        for (i = `SPECIAL_N - 1; i >= 0; i = i - 1) begin
            if (!list_used_q[list_base_w + i[2:0]]) begin
                free_slot_w = list_base_w + i[2:0];
                free_any_w = 1'b1;
            end
        end
    end

    // List edit: 1 clear, 2 add, 3 remove
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            list_used_q <= 8'h00;
            for (i = 0; i < 8; i = i + 1) begin
                list_call_q[i] <= {`CALL_W{1'b0}};
            end
        end else begin
            case (list_op_i)
                2'h1: begin
                    list_used_q[list_base_w +: 4] <= 4'h0;
                end
                2'h2: begin
                    if (free_any_w && !(|list_hit_w[list_base_w +: 4])) begin
                        list_used_q[free_slot_w] <= 1'b1;
                        list_call_q[free_slot_w] <= list_call_i;
                    end
                end
                2'h3: begin
                    list_used_q[list_base_w +: 4] <=
                        list_used_q[list_base_w +: 4] & ~list_hit_w[list_base_w +: 4];
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Address classification
    // ************************************************************
    reg special_hit_w; // Next call is a special relay callsign
    wire [2:0] port_base_w; // Receive port list base
    wire flood_hit_w; // Alias plus digit with id 1-7
    wire trace_hit_w; // Trace alias plus digit with id 1-7
    wire gate_hit_w; // Gateway alias

    assign port_base_w = {rx_port_i, 2'b00};

    // Compare against the receive port's special list
    always @* begin
        special_hit_w = 1'b0;
        for (i = 0; i < `SPECIAL_N; i = i + 1) begin
            // Inline compare keeps every read in the sensitivity list
            if (list_used_q[port_base_w + i[2:0]] &&
                (list_call_q[port_base_w + i[2:0]] == next_call_i)) begin
                special_hit_w = 1'b1;
            end
        end
    end

    // Alias of len chars (left-justified), then digit '1'..'7', then spaces
    function alias_match;
        input [`CALL_W-1:0] call;
        input [`CALL_W-1:0] alias_call;
        input [2:0] len;
        input [`SSID_W-1:0] ssid;
        reg [7:0] c;
        reg ok;
        integer j;
        begin
            ok = (len != 3'h0) && (len <= 3'h5);
            ok = ok && (ssid >= 4'h1) && (ssid <= 4'h7);
            for (j = 0; j < 6; j = j + 1) begin
                c = call[`CALL_W-1-8*j -: 8];
                if (j < len) begin
                    ok = ok && (c == alias_call[`CALL_W-1-8*j -: 8]);
                end else if (j == len) begin
                    ok = ok && (c >= 8'h31) && (c <= 8'h37);
                end else begin
                    ok = ok && (c == 8'h20);
                end
            end
            alias_match = ok;
        end
    endfunction

    assign flood_hit_w = flood_en_i &&
        alias_match(next_call_i, flood_alias_relay_i, flood_alias_len_i, next_ssid_i);
    assign trace_hit_w = trace_en_i &&
        alias_match(next_call_i, trace_alias_relay_i, trace_alias_len_i, next_ssid_i);
    assign gate_hit_w = (next_call_i == gateway_alias_i);

    // ************************************************************
    // Hold tick and duplicate history
    // ************************************************************
    reg [31:0] sec_cnt_q; // Cycles within the current second
    reg tick_q; // One pulse per second

    // Second divider for the hold timers
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            sec_cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else if (sec_cnt_q == SEC_CYCLES - 1) begin
            sec_cnt_q <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            sec_cnt_q <= sec_cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    reg [2:0] kind_w; // Classified relay kind
    reg [7:0] hold_w; // Hold time for the kind
    reg pend_q; // Frame awaiting history answer
    reg [2:0] kind_q;
    reg port_q;
    reg [`CALL_W-1:0] call_q;
    reg [`SSID_W-1:0] ssid_q;
    reg [3:0] index_q;
    reg [3:0] rpt_q;
    reg [`CRC_W-1:0] crc_q;
    reg [7:0] hold_q;
    wire dup_hit_w; // History answer, one cycle after lookup
    wire insert_w; // Record a relayed frame

    // Pick the kind; own callsign in path blocks special and trace
    always @* begin
        kind_w = `KIND_NONE;
        hold_w = relay_duplicate_hold_i;
        if (!is_ui_i) begin
            kind_w = `KIND_NONE;
        end else if (gate_hit_w) begin
            kind_w = `KIND_GATE;
        end else if (special_hit_w && !own_in_path_i) begin
            kind_w = `KIND_SPECIAL;
        end else if (flood_hit_w) begin
            kind_w = `KIND_FLOOD;
            hold_w = flood_hold_i;
        end else if (trace_hit_w && !own_in_path_i) begin
            kind_w = `KIND_TRACE;
            hold_w = trace_hold_i;
        end
    end

    assign insert_w = pend_q && !dup_hit_w && (hold_q != 8'h00) &&
        (kind_q != `KIND_NONE) && (kind_q != `KIND_GATE);

    dup_history #(
        .DEPTH(`HIST_DEPTH),
        .AW(6),
        .CW(`CRC_W)
    ) u_hist (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(tick_q),
        .lookup_i(hdr_valid_i && (hold_w != 8'h00)),
        .crc_i(pend_q ? crc_q : frame_crc_i),
        .insert_i(insert_w),
        .hold_i(hold_q),
        .hit_o(dup_hit_w)
    );

    // ************************************************************
    // Decision stage
    // ************************************************************
    // Capture the header, then issue the decision one cycle later
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            pend_q <= 1'b0;
            kind_q <= `KIND_NONE;
            port_q <= 1'b0;
            call_q <= {`CALL_W{1'b0}};
            ssid_q <= 4'h0;
            index_q <= 4'h0;
            rpt_q <= 4'h0;
            crc_q <= `CRC_INIT;
            hold_q <= 8'h00;
        end else begin
            pend_q <= hdr_valid_i;
            if (hdr_valid_i) begin
                kind_q <= kind_w;
                port_q <= rx_port_i;
                call_q <= next_call_i;
                ssid_q <= next_ssid_i;
                index_q <= next_index_i;
                rpt_q <= rpt_count_i;
                crc_q <= frame_crc_i;
                hold_q <= hold_w;
            end
        end
    end

    // Build the rewrite instructions for the transmit queue
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            dec_valid_o <= 1'b0;
            dec_relay_o <= 1'b0;
            dec_kind_o <= `KIND_NONE;
            dec_tx_port_o <= 1'b0;
            dec_call_o <= {`CALL_W{1'b0}};
            dec_ssid_o <= 4'h0;
            dec_hbit_o <= 1'b0;
            dec_index_o <= 4'h0;
            dec_insert_o <= 1'b0;
            dec_append_o <= 1'b0;
            dec_wait_o <= 1'b0;
        end else begin
            dec_valid_o <= pend_q;
            dec_kind_o <= kind_q;
            dec_index_o <= index_q;
            dec_tx_port_o <= port_q;
            dec_call_o <= call_q;
            dec_ssid_o <= ssid_q;
            dec_hbit_o <= 1'b0;
            dec_insert_o <= 1'b0;
            dec_append_o <= 1'b0;
            dec_wait_o <= 1'b1;
            dec_relay_o <= 1'b0;
            case (kind_q)
                `KIND_SPECIAL: begin
                    dec_relay_o <= !dup_hit_w;
                    dec_call_o <= own_callsign_i;
                    dec_hbit_o <= 1'b1;
                    dec_wait_o <= special_wait_i;
                end
                `KIND_FLOOD: begin
                    dec_relay_o <= !dup_hit_w;
                    dec_ssid_o <= ssid_q - 4'h1;
                    dec_append_o <= !no_callsign_insert_i;
                    dec_wait_o <= special_wait_i;
                end
                `KIND_TRACE: begin
                    dec_relay_o <= !dup_hit_w;
                    dec_ssid_o <= ssid_q - 4'h1;
                    dec_insert_o <= (rpt_q < 4'h8);
                    dec_wait_o <= special_wait_i;
                end
                `KIND_GATE: begin
                    dec_relay_o <= port_gateway_enable_i[port_q];
                    dec_tx_port_o <= ~port_q;
                end
                default: begin
                    dec_relay_o <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Unconnected-mode send gate
    // ************************************************************
    // Path none blocks all but beacon frames
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            ucon_send_o <= 1'b0;
            ucon_ui_o <= 1'b1;
            ucon_retry_o <= 1'b0;
        end else begin
            ucon_send_o <= path_beacon_i || (path_send_i && !path_none_i);
            ucon_ui_o <= 1'b1;
            ucon_retry_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ### ui_relay_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "ui_relay_defs.vh"
// ************
// Decision checker
// ************
module ui_relay_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic hdr_valid_i,
    input wire logic rx_port_i,
    input wire logic is_ui_i,
    input wire logic [`CALL_W-1:0] next_call_i,
    input wire logic [`SSID_W-1:0] next_ssid_i,
    input wire logic [3:0] rpt_count_i,
    input wire logic own_in_path_i,
    input wire logic [`CALL_W-1:0] own_callsign_i,
    input wire logic [`CALL_W-1:0] gateway_alias_i,
    input wire logic [1:0] port_gateway_enable_i,
    input wire logic no_callsign_insert_i,
    input wire logic special_wait_i,
    input wire logic path_none_i,
    input wire logic path_send_i,
    input wire logic path_beacon_i,
    input wire logic dec_valid_o,
    input wire logic dec_relay_o,
    input wire logic [2:0] dec_kind_o,
    input wire logic dec_tx_port_o,
    input wire logic [`CALL_W-1:0] dec_call_o,
    input wire logic [`SSID_W-1:0] dec_ssid_o,
    input wire logic dec_hbit_o,
    input wire logic dec_insert_o,
    input wire logic dec_append_o,
    input wire logic dec_wait_o,
    input wire logic ucon_send_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Header accepted as UI, gateway address seen, relayed decision
    wire hdr_ui = hdr_valid_i && is_ui_i;
    wire is_gate = next_call_i == gateway_alias_i;
    wire rel = dec_valid_o && dec_relay_o;
    property p_non_ui;
        hdr_valid_i && !is_ui_i |-> ##2 dec_valid_o && !dec_relay_o && dec_kind_o == `KIND_NONE;
    endproperty
    a_non_ui: assert property (p_non_ui) else $error("non-UI frame not refused");
    property p_gate_on;
        hdr_ui && is_gate && port_gateway_enable_i[rx_port_i] |-> ##2
            rel && dec_kind_o == `KIND_GATE && dec_tx_port_o != $past(rx_port_i, 2);
    endproperty
    a_gate_on: assert property (p_gate_on) else $error("gateway frame not crossed");
    property p_gate_off;
        hdr_ui && is_gate && !port_gateway_enable_i[rx_port_i] |-> ##2 dec_valid_o && !dec_relay_o;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gateway frame not dropped");
    property p_own_block;
        hdr_ui && own_in_path_i && !is_gate |-> ##2
            dec_kind_o != `KIND_SPECIAL && dec_kind_o != `KIND_TRACE;
    endproperty
    a_own_block: assert property (p_own_block) else $error("relay despite own call");
    property p_special;
        rel && dec_kind_o == `KIND_SPECIAL |-> dec_hbit_o && dec_call_o == own_callsign_i;
    endproperty
    a_special: assert property (p_special) else $error("special rewrite wrong");
    property p_flood;
        rel && dec_kind_o == `KIND_FLOOD |-> !dec_hbit_o && !dec_insert_o
            && dec_ssid_o == $past(next_ssid_i, 2) - 4'h1
            && dec_append_o == !$past(no_callsign_insert_i);
    endproperty
    a_flood: assert property (p_flood) else $error("flood edit wrong");
    property p_trace;
        rel && dec_kind_o == `KIND_TRACE |-> !dec_hbit_o
            && dec_ssid_o == $past(next_ssid_i, 2) - 4'h1 && dec_insert_o == ($past(rpt_count_i, 2) < 4'h8);
    endproperty
    a_trace: assert property (p_trace) else $error("trace edit wrong");
    property p_wait;
        rel && dec_kind_o != `KIND_GATE |-> dec_wait_o == $past(special_wait_i);
    endproperty
    a_wait: assert property (p_wait) else $error("relay wait wrong");
    property p_ucon;
        (path_send_i && !path_none_i) || path_beacon_i |=> ucon_send_o;
    endproperty
    a_ucon: assert property (p_ucon) else $error("unconnected frame not sent");
    property p_ucon_none;
        !path_beacon_i && (path_none_i || !path_send_i) |=> !ucon_send_o;
    endproperty
    a_ucon_none: assert property (p_ucon_none) else $error("frame sent with path none");
    // Main relay kinds reached
    c_special: cover property (rel && dec_kind_o == `KIND_SPECIAL);
    c_flood: cover property (rel && dec_kind_o == `KIND_FLOOD);
    c_trace: cover property (rel && dec_kind_o == `KIND_TRACE && !dec_insert_o);
endmodule
`default_nettype wire

// ### rx_frame_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "ui_relay_defs.vh"
// ************
// Frame receiver model
// ************
module rx_frame_model (
    input wire logic clk_i,
    output logic hdr_valid_o,
    output logic rx_port_o,
    output logic is_ui_o,
    output logic [`CALL_W-1:0] next_call_o,
    output logic [`SSID_W-1:0] next_ssid_o,
    output logic [3:0] rpt_count_o,
    output logic own_in_path_o,
    output logic [`CRC_W-1:0] frame_crc_o
);
    initial begin
        {hdr_valid_o, rx_port_o, is_ui_o, next_call_o, next_ssid_o} = '0;
        {rpt_count_o, own_in_path_o, frame_crc_o} = '0;
    end
    // One header for one cycle; released fields other than port and UI flag are scrambled so that
    // a stale summary cannot pass for a held one
    task send(input logic p, input logic ui, input logic [47:0] c, input logic [3:0] s,
              input logic [3:0] r, input logic own, input logic [15:0] crc);
        begin
            {rx_port_o, is_ui_o, next_call_o, next_ssid_o} = {p, ui, c, s};
            {rpt_count_o, own_in_path_o, frame_crc_o} = {r, own, crc};
            hdr_valid_o = 1'b1;
            @(posedge clk_i);
            #1;
            hdr_valid_o = 1'b0;
            {next_call_o, next_ssid_o, rpt_count_o} = ~{next_call_o, next_ssid_o, rpt_count_o};
            {own_in_path_o, frame_crc_o} = ~{own_in_path_o, frame_crc_o};
            // Decision stands after the next edge
            @(posedge clk_i);
            #1;
        end
    endtask
endmodule
`default_nettype wire

// ### test_ui_frame_digipeater.sv
`timescale 1ns/1ps
`default_nettype none
`include "ui_relay_defs.vh"
// ************
// Relay decision bench
// ************
module test_ui_frame_digipeater;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    wire hdr_valid_i, rx_port_i, is_ui_i, own_in_path_i;
    wire [`CALL_W-1:0] next_call_i;
    wire [`SSID_W-1:0] next_ssid_i;
    wire [3:0] rpt_count_i;
    wire [`CRC_W-1:0] frame_crc_i;
    logic [`CALL_W-1:0] src_call_i = "SRC   ";
    logic [3:0] next_index_i = 4'h0;
    logic [`CALL_W-1:0] own_callsign_i = "OWNSTN";
    logic [`CALL_W-1:0] gateway_alias_i = "GATE  ";
    logic [1:0] port_gateway_enable_i = 2'h1;
    logic [1:0] list_op_i = 2'h0;
    logic list_port_i = 1'b0;
    logic [`CALL_W-1:0] list_call_i = "NONE  ";
    logic [`CALL_W-1:0] flood_alias_relay_i = "WIDE  ";
    logic [`CALL_W-1:0] trace_alias_relay_i = "TRACE ";
    logic [2:0] flood_alias_len_i = 3'h4;
    logic [2:0] trace_alias_len_i = 3'h5;
    logic flood_en_i = 1'b0, no_callsign_insert_i = 1'b0, trace_en_i = 1'b0, special_wait_i = 1'b0;
    logic [7:0] relay_duplicate_hold_i = 8'h0, flood_hold_i = 8'h2, trace_hold_i = 8'h2;
    logic path_none_i = 1'b0, path_send_i = 1'b0, path_beacon_i = 1'b0;
    wire dec_valid_o, dec_relay_o, dec_tx_port_o, dec_hbit_o, dec_insert_o, dec_append_o;
    wire dec_wait_o, ucon_send_o, ucon_ui_o, ucon_retry_o;
    wire [2:0] dec_kind_o;
    wire [`CALL_W-1:0] dec_call_o;
    wire [`SSID_W-1:0] dec_ssid_o;
    wire [3:0] dec_index_o;
    int bad_count = 0;
    int total_checks = 0;
    int i;
    always #5 clk_i = ~clk_i;
    rx_frame_model pm (.clk_i, .hdr_valid_o(hdr_valid_i), .rx_port_o(rx_port_i),
        .is_ui_o(is_ui_i), .next_call_o(next_call_i), .next_ssid_o(next_ssid_i),
        .rpt_count_o(rpt_count_i), .own_in_path_o(own_in_path_i), .frame_crc_o(frame_crc_i));
    ui_frame_digipeater #(.SEC_CYCLES(100)) dut (.*);
    // ************
    // Tasks
    // ************
    task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    // Decision present, relay flag and kind when relayed
    task dec(input logic relay, input logic [2:0] kind);
        begin
            chk("dec_valid_o", dec_valid_o, 1'b1);
            chk("dec_relay_o", dec_relay_o, relay);
            if (relay)
                chk("dec_kind_o", dec_kind_o, kind);
        end
    endtask
    // Special candidate: UI, one repeater field, own call absent
    task sp(input logic p, input logic [47:0] c, input logic [15:0] crc, input logic rl);
        begin
            pm.send(p, 1'b1, c, 4'h0, 4'h1, 1'b0, crc);
            dec(rl, `KIND_SPECIAL);
        end
    endtask
    // List edit, one pulse then a quiet cycle
    task lop(input logic [1:0] op, input logic port, input logic [47:0] c);
        begin
            {list_op_i, list_port_i, list_call_i} = {op, port, c};
            @(posedge clk_i);
            #1;
            list_op_i = 2'h0;
            @(posedge clk_i);
            #1;
        end
    endtask
    // Unconnected request pulse and the one-cycle answer
    task ucon(input logic s, input logic b, input logic exp);
        begin
            {path_send_i, path_beacon_i} = {s, b};
            @(posedge clk_i);
            #1;
            {path_send_i, path_beacon_i} = 2'h0;
            chk("ucon_send_o", ucon_send_o, exp);
            @(posedge clk_i);
            #1;
            chk("ucon_send_o", ucon_send_o, 1'b0);
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count = bad_count + 1;
        test_done;
    end
    // ************
    // Main sequence
    // ************
    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        chk("ucon_ui_o", ucon_ui_o, 1'b1);
        chk("ucon_retry_o", ucon_retry_o, 1'b0);
        chk("dec_valid_o", dec_valid_o, 1'b0);
        rst_n_i = 1'b1;
        lop(2'h2, 1'b0, "RELAY ");
        sp(1'b0, "RELAY ", 16'h1111, 1'b1);
        chk("dec_call_o", dec_call_o, "OWNSTN");
        chk("dec_hbit_o", dec_hbit_o, 1'b1);
        chk("dec_wait_o", dec_wait_o, 1'b0);
        pm.send(1'b0, 1'b1, "RELAY ", 4'h0, 4'h1, 1'b1, 16'h2222);
        dec(1'b0, `KIND_NONE);
        sp(1'b0, "RELAY ", 16'h1111, 1'b1);
        relay_duplicate_hold_i = 8'h2;
        sp(1'b0, "RELAY ", 16'h3333, 1'b1);
        sp(1'b0, "RELAY ", 16'h3333, 1'b0);
        repeat (350) @(posedge clk_i);
        #1;
        special_wait_i = 1'b1;
        sp(1'b0, "RELAY ", 16'h3333, 1'b1);
        chk("dec_wait_o", dec_wait_o, 1'b1);
        special_wait_i = 1'b0;
        for (i = 0; i < 5; i = i + 1)
            lop(2'h2, 1'b1, {"CALL", 8'h30 + i[7:0], " "});
        sp(1'b1, "CALL3 ", 16'h5556, 1'b1);
        sp(1'b1, "CALL4 ", 16'h5557, 1'b0);
        sp(1'b1, "RELAY ", 16'h5558, 1'b0);
        lop(2'h3, 1'b0, "RELAY ");
        lop(2'h1, 1'b1, "NONE  ");
        sp(1'b0, "RELAY ", 16'h6666, 1'b0);
        sp(1'b1, "CALL0 ", 16'h6667, 1'b0);
        $display("test special done");
        flood_en_i = 1'b1;
        pm.send(1'b0, 1'b1, "WIDE2 ", 4'h2, 4'h1, 1'b0, 16'h7001);
        dec(1'b1, `KIND_FLOOD);
        chk("dec_ssid_o", dec_ssid_o, 4'h1);
        chk("dec_hbit_o", dec_hbit_o, 1'b0);
        chk("dec_append_o", dec_append_o, 1'b1);
        pm.send(1'b0, 1'b1, "WIDE2 ", 4'h2, 4'h1, 1'b0, 16'h7001);
        dec(1'b0, `KIND_NONE);
        no_callsign_insert_i = 1'b1;
        pm.send(1'b0, 1'b1, "WIDE7 ", 4'h7, 4'h1, 1'b0, 16'h7002);
        dec(1'b1, `KIND_FLOOD);
        chk("dec_append_o", dec_append_o, 1'b0);
        pm.send(1'b0, 1'b1, "WIDE8 ", 4'h2, 4'h1, 1'b0, 16'h7003);
        dec(1'b0, `KIND_NONE);
        pm.send(1'b0, 1'b1, "WIDE2 ", 4'h8, 4'h1, 1'b0, 16'h7004);
        dec(1'b0, `KIND_NONE);
        flood_en_i = 1'b0;
        $display("test flood done");
        trace_en_i = 1'b1;
        pm.send(1'b0, 1'b1, "TRACE3", 4'h3, 4'h2, 1'b0, 16'h8001);
        dec(1'b1, `KIND_TRACE);
        chk("dec_insert_o", dec_insert_o, 1'b1);
        chk("dec_ssid_o", dec_ssid_o, 4'h2);
        pm.send(1'b0, 1'b1, "TRACE3", 4'h3, 4'h2, 1'b0, 16'h8001);
        dec(1'b0, `KIND_NONE);
        pm.send(1'b0, 1'b1, "TRACE3", 4'h3, 4'h8, 1'b0, 16'h8002);
        dec(1'b1, `KIND_TRACE);
        chk("dec_insert_o", dec_insert_o, 1'b0);
        pm.send(1'b0, 1'b1, "TRACE3", 4'h3, 4'h2, 1'b1, 16'h8003);
        dec(1'b0, `KIND_NONE);
        $display("test trace done");
        pm.send(1'b0, 1'b1, "GATE  ", 4'h0, 4'h1, 1'b0, 16'h9001);
        dec(1'b1, `KIND_GATE);
        chk("dec_tx_port_o", dec_tx_port_o, 1'b1);
        pm.send(1'b1, 1'b1, "GATE  ", 4'h0, 4'h1, 1'b0, 16'h9002);
        dec(1'b0, `KIND_NONE);
        pm.send(1'b0, 1'b0, "GATE  ", 4'h0, 4'h1, 1'b0, 16'h9003);
        chk("dec_kind_o", dec_kind_o, `KIND_NONE);
        $display("test gateway done");
        ucon(1'b1, 1'b0, 1'b1);
        path_none_i = 1'b1;
        ucon(1'b1, 1'b0, 1'b0);
        ucon(1'b0, 1'b1, 1'b1);
        $display("test unconnected done");
        test_done;
    end
endmodule
bind ui_frame_digipeater ui_relay_checker u_chk (.*);
`default_nettype wire
